// file: src/tocmp_pkg.sv
// constants, register map and types for the 16-bit timer output compare block
package tocmp_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CNT_LOW    = 4'h0;
    localparam logic [3:0] ADDR_CNT_HIGH   = 4'h1;
    localparam logic [3:0] ADDR_CMPA_LOW   = 4'h2;
    localparam logic [3:0] ADDR_CMPA_HIGH  = 4'h3;
    localparam logic [3:0] ADDR_CMPB_LOW   = 4'h4;
    localparam logic [3:0] ADDR_CMPB_HIGH  = 4'h5;
    localparam logic [3:0] ADDR_CAPT_LOW   = 4'h6;
    localparam logic [3:0] ADDR_CAPT_HIGH  = 4'h7;
    localparam logic [3:0] ADDR_CTRL_A     = 4'h8;
    localparam logic [3:0] ADDR_CTRL_B     = 4'h9;
    localparam logic [3:0] ADDR_FORCE      = 4'ha;
    localparam logic [3:0] ADDR_IRQ_EN     = 4'hb;
    localparam logic [3:0] ADDR_FLAGS      = 4'hc;
    localparam logic [3:0] ADDR_PIN_DIR    = 4'hd;
    localparam logic [3:0] ADDR_PORT_VAL   = 4'he;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    // control a: [1:0] mode low bits, [5:4] action b, [7:6] action a
    localparam int CTRLA_MODE_LSB = 0;
    localparam int CTRLA_ACTB_LSB = 4;
    localparam int CTRLA_ACTA_LSB = 6;
    // control b: [1:0] mode high bits, [2] timer clock enable
    localparam int CTRLB_MODE_LSB = 0;
    localparam int CTRLB_RUN_BIT  = 2;
    // force, irq enable, flags, pin direction, port value: bit 0 = a, bit 1 = b
    localparam int FLAG_OVF_BIT   = 2;

    // ------------------------------------------------------------------
    // reset values and fixed counts
    // ------------------------------------------------------------------
    localparam logic [15:0] CNT_MAX       = 16'hffff;
    localparam logic [15:0] CNT_BOTTOM    = 16'h0000;
    localparam logic [15:0] TOP_8BIT      = 16'h00ff;
    localparam logic [15:0] TOP_9BIT      = 16'h01ff;
    localparam logic [15:0] TOP_10BIT     = 16'h03ff;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    localparam logic [15:0] WORD_RESET    = 16'h0000;

    // waveform modes
    localparam logic [3:0] WM_NORMAL      = 4'h0;
    localparam logic [3:0] WM_CTC_CMPA    = 4'h4;
    localparam logic [3:0] WM_FAST_8      = 4'h5;
    localparam logic [3:0] WM_FAST_9      = 4'h6;
    localparam logic [3:0] WM_FAST_10     = 4'h7;
    localparam logic [3:0] WM_CTC_CAPT    = 4'hc;
    localparam logic [3:0] WM_FAST_CAPT   = 4'he;
    localparam logic [3:0] WM_FAST_CMPA   = 4'hf;

    // compare output actions
    localparam logic [1:0] ACT_NONE       = 2'h0;
    localparam logic [1:0] ACT_TOGGLE     = 2'h1;
    localparam logic [1:0] ACT_CLEAR      = 2'h2;
    localparam logic [1:0] ACT_SET        = 2'h3;

    typedef enum logic [1:0] {
        TOCMP_SLOPE_UP,
        TOCMP_SLOPE_DOWN
    } tocmp_slope_e;
endpackage

// file: src/tocmp_top.sv
// output compare unit of a 16-bit timer with register port and pin override
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/10ps
//
// Overview of operation
// - compare full count with each value always
// - flag rises one timer tick after match
// - enabled flag requests irq, ack clears it
// - writing one clears flag, zero ignored
// - channel a value is top in some modes
// - double buffer in pwm, not normal/ctc
// - buffer copies to active at top/bottom
// - writes go to buffer or active register
// - compare reads bypass shared high latch
// - low write merges latched high same cycle
// - non-pwm force updates output only, no flag
// - count write blocks next tick matches
// - output state survives mode changes
// - action bits unbuffered, next match applies
// - reset clears output state to zero
// - nonzero action overrides port value
// - pin shows output only when direction out
// - action zero leaves output unchanged
// - mode sets counting, action sets output
// - normal mode counts up, wraps ffff
// - overflow flag set when count wraps to zero from ffff or pwm top, in dual slope as it leaves zero
// - modes 4/12 clear on match a/capture
// - non-pwm action one toggles on match
module tocmp_top (
    input  wire logic                mclk_i,
    input  wire logic                rstn_i,
    input  wire logic                cen_i,
    input  wire logic                timer_tick_i,
    input  wire logic [3:0]          addr_i,
    input  wire logic [7:0]          wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    input  wire logic [1:0]          irq_ack_i,
    output logic      [7:0]          rdata_o,
    output logic      [1:0]          irq_o,
    output logic                     ovf_flag_o,
    output logic      [1:0]          pin_out_o,
    output logic      [1:0]          pin_oe_o
);
    import tocmp_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0]  count;
        logic [7:0]   temp_hi;
        logic [15:0]  cmp_act_a;
        logic [15:0]  cmp_act_b;
        logic [15:0]  cmp_buf_a;
        logic [15:0]  cmp_buf_b;
        logic [15:0]  capt;
        logic [7:0]   ctrl_a;
        logic [7:0]   ctrl_b;
        logic [1:0]   irq_en;
        logic [1:0]   match_flag;
        logic         ovf_flag;
        logic [1:0]   out_state;
        logic [1:0]   pin_dir;
        logic [1:0]   port_val;
        logic [1:0]   match_pend;
        logic         block_next;
        tocmp_slope_e slope;
        logic [7:0]   rdata;
        logic [1:0]   irq;
        logic [1:0]   pin_out;
        logic [1:0]   pin_oe;
    } tocmp_state_s;

    tocmp_state_s st_r;
    tocmp_state_s st_nxt;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // pwm modes: every mode other than normal, ctc and the reserved 13
    function automatic logic tocmp_is_pwm(input logic [3:0] m);
        tocmp_is_pwm = !(m == WM_NORMAL || m == WM_CTC_CMPA || m == WM_CTC_CAPT
                         || m == 4'hd);
    endfunction

    // dual-slope pwm modes count up and down
    function automatic logic tocmp_is_dual(input logic [3:0] m);
        tocmp_is_dual = (m[3:2] == 2'b10) || (m[3:2] == 2'b00 && m != WM_NORMAL
                        && m != WM_CTC_CMPA);
    endfunction

    // top value selected by the waveform mode
    function automatic logic [15:0] tocmp_top_val(input logic [3:0] m,
                                                  input logic [15:0] cmpa,
                                                  input logic [15:0] capt);
        case (m)
            4'h1, WM_FAST_8:                 tocmp_top_val = TOP_8BIT;
            4'h2, WM_FAST_9:                 tocmp_top_val = TOP_9BIT;
            4'h3, WM_FAST_10:                tocmp_top_val = TOP_10BIT;
            WM_CTC_CMPA, 4'h9, 4'hb, WM_FAST_CMPA: tocmp_top_val = cmpa;
            4'h8, 4'ha, WM_CTC_CAPT, WM_FAST_CAPT: tocmp_top_val = capt;
            default:                         tocmp_top_val = CNT_MAX;
        endcase
    endfunction

    // non-pwm action on a match
    function automatic logic tocmp_act(input logic [1:0] act, input logic cur);
        case (act)
            ACT_TOGGLE: tocmp_act = ~cur;
            ACT_CLEAR:  tocmp_act = 1'b0;
            ACT_SET:    tocmp_act = 1'b1;
            default:    tocmp_act = cur;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // decoded views of the control registers
    // ------------------------------------------------------------------
    logic [3:0]  mode;
    logic [1:0]  act [2];
    logic        pwm;
    logic        dual;
    logic [15:0] top;
    logic        at_top;
    logic        at_bottom;
    logic        tick;

    always_comb begin
        mode   = {st_r.ctrl_b[CTRLB_MODE_LSB +: 2], st_r.ctrl_a[CTRLA_MODE_LSB +: 2]};
        act[0] = st_r.ctrl_a[CTRLA_ACTA_LSB +: 2];
        act[1] = st_r.ctrl_a[CTRLA_ACTB_LSB +: 2];
        pwm    = tocmp_is_pwm(mode);
        dual   = tocmp_is_dual(mode);
        top    = tocmp_top_val(mode, st_r.cmp_act_a, st_r.capt);
        at_top    = (st_r.count == top);
        at_bottom = (st_r.count == CNT_BOTTOM);
        tick   = timer_tick_i && st_r.ctrl_b[CTRLB_RUN_BIT];
    end

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    // one process so every effect of a bus access and a tick is ordered here
    always_comb begin
        logic [1:0]  match;
        logic [1:0]  force_hit;
        logic [15:0] wide;
        logic        wrap;
        logic        do_load;
        match     = 2'b00;
        force_hit = 2'b00;
        wide      = {st_r.temp_hi, wdata_i};
        wrap      = 1'b0;
        do_load   = 1'b0;
        st_nxt    = st_r;
        st_nxt.rdata = BYTE_RESET;

        // comparators run on every cycle against the active values
        match[0] = (st_r.count == st_r.cmp_act_a);
        match[1] = (st_r.count == st_r.cmp_act_b);

        // timer tick: count sequence from mode only
        if (tick) begin
            // a count write blocks this tick's matches even if stopped
            st_nxt.match_pend = st_r.block_next ? 2'b00 : match;
            st_nxt.block_next = 1'b0;
            if (!pwm) begin
                // ctc clears on top, normal always wraps at max
                if (mode != WM_NORMAL && at_top) begin
                    st_nxt.count = CNT_BOTTOM;
                end else begin
                    st_nxt.count = st_r.count + 16'h0001;
                    wrap = (st_r.count == CNT_MAX);
                end
            end else if (!dual) begin
                if (at_top) begin
                    st_nxt.count = CNT_BOTTOM;
                    do_load = 1'b1;
                    wrap = 1'b1;
                end else begin
                    st_nxt.count = st_r.count + 16'h0001;
                end
            end else begin
                if (st_r.slope == TOCMP_SLOPE_UP) begin
                    if (at_top) begin
                        st_nxt.slope = TOCMP_SLOPE_DOWN;
                        st_nxt.count = st_r.count - 16'h0001;
                        do_load = 1'b1;
                    end else begin
                        st_nxt.count = st_r.count + 16'h0001;
                    end
                end else if (at_bottom) begin
                    st_nxt.slope = TOCMP_SLOPE_UP;
                    st_nxt.count = st_r.count + 16'h0001;
                    wrap = 1'b1;
                end else begin
                    st_nxt.count = st_r.count - 16'h0001;
                end
            end
            // overflow flag only set by hardware, with the zero count; dual slope on the tick leaving zero
            if (wrap) begin
                st_nxt.ovf_flag = 1'b1;
            end
            // matches from the previous tick raise flags now
            st_nxt.match_flag = st_r.match_flag | st_r.match_pend;
            // apply actions on match; action read live, not buffered
            for (int c = 0; c < 2; c++) begin
                if (st_r.match_pend[c]) begin
                    if (!pwm) begin
                        st_nxt.out_state[c] = tocmp_act(act[c], st_r.out_state[c]);
                    end else if (act[c][1]) begin
                        // non-inverted clears on match, inverted sets; dual slope does so counting down, the reverse counting up
                        st_nxt.out_state[c] = act[c][0] ^ dual ^ (st_r.slope == TOCMP_SLOPE_DOWN)
                                              ? 1'b1 : 1'b0;
                    end
                end
                if (pwm && !dual && wrap && act[c][1]) begin
                    st_nxt.out_state[c] = ~act[c][0];
                end
            end
            if (do_load) begin
                st_nxt.cmp_act_a = st_r.cmp_buf_a;
                st_nxt.cmp_act_b = st_r.cmp_buf_b;
            end
        end

        // buffers follow active values whenever buffering is off
        if (!pwm) begin
            st_nxt.cmp_buf_a = st_nxt.cmp_act_a;
            st_nxt.cmp_buf_b = st_nxt.cmp_act_b;
        end

        // interrupt service clears the flag; a same-cycle set still wins
        for (int c = 0; c < 2; c++) begin
            if (irq_ack_i[c] && !(tick && st_r.match_pend[c])) begin
                st_nxt.match_flag[c] = 1'b0;
            end
        end

        // bus writes
        if (wr_i) begin
            case (addr_i)
                ADDR_CNT_HIGH, ADDR_CMPA_HIGH, ADDR_CMPB_HIGH, ADDR_CAPT_HIGH: begin
                    st_nxt.temp_hi = wdata_i;
                end
                ADDR_CNT_LOW: begin
                    // write beats count, and blocks the next tick's matches
                    st_nxt.count      = wide;
                    st_nxt.block_next = 1'b1;
                end
                ADDR_CMPA_LOW: begin
                    // buffer in pwm, active otherwise, both bytes at once
                    st_nxt.cmp_buf_a = wide;
                    if (!pwm) begin
                        st_nxt.cmp_act_a = wide;
                    end
                end
                ADDR_CMPB_LOW: begin
                    st_nxt.cmp_buf_b = wide;
                    if (!pwm) begin
                        st_nxt.cmp_act_b = wide;
                    end
                end
                ADDR_CAPT_LOW:  st_nxt.capt   = wide;
                ADDR_CTRL_A:    st_nxt.ctrl_a = wdata_i;
                ADDR_CTRL_B:    st_nxt.ctrl_b = wdata_i;
                ADDR_FORCE: begin
                    // force acts on the output only, never on flag or count
                    if (!pwm) begin
                        force_hit = wdata_i[1:0];
                        for (int c = 0; c < 2; c++) begin
                            if (force_hit[c]) begin
                                st_nxt.out_state[c] = tocmp_act(act[c], st_nxt.out_state[c]);
                            end
                        end
                    end
                end
                ADDR_IRQ_EN:    st_nxt.irq_en = wdata_i[1:0];
                ADDR_FLAGS: begin
                    // one clears, zero keeps; a set this cycle wins
                    for (int c = 0; c < 2; c++) begin
                        if (wdata_i[c] && !(tick && st_r.match_pend[c])) begin
                            st_nxt.match_flag[c] = 1'b0;
                        end
                    end
                    if (wdata_i[FLAG_OVF_BIT] && !wrap) begin
                        st_nxt.ovf_flag = 1'b0;
                    end
                end
                ADDR_PIN_DIR:   st_nxt.pin_dir  = wdata_i[1:0];
                ADDR_PORT_VAL:  st_nxt.port_val = wdata_i[1:0];
                default: ;
            endcase
        end

        // bus reads; compare bytes come straight from storage
        if (rd_i) begin
            case (addr_i)
                ADDR_CNT_LOW: begin
                    st_nxt.rdata   = st_r.count[7:0];
                    st_nxt.temp_hi = st_r.count[15:8];
                end
                ADDR_CNT_HIGH:  st_nxt.rdata = st_r.temp_hi;
                ADDR_CAPT_LOW: begin
                    st_nxt.rdata   = st_r.capt[7:0];
                    st_nxt.temp_hi = st_r.capt[15:8];
                end
                ADDR_CAPT_HIGH: st_nxt.rdata = st_r.temp_hi;
                ADDR_CMPA_LOW:  st_nxt.rdata = pwm ? st_r.cmp_buf_a[7:0]  : st_r.cmp_act_a[7:0];
                ADDR_CMPA_HIGH: st_nxt.rdata = pwm ? st_r.cmp_buf_a[15:8] : st_r.cmp_act_a[15:8];
                ADDR_CMPB_LOW:  st_nxt.rdata = pwm ? st_r.cmp_buf_b[7:0]  : st_r.cmp_act_b[7:0];
                ADDR_CMPB_HIGH: st_nxt.rdata = pwm ? st_r.cmp_buf_b[15:8] : st_r.cmp_act_b[15:8];
                ADDR_CTRL_A:    st_nxt.rdata = st_r.ctrl_a;
                ADDR_CTRL_B:    st_nxt.rdata = st_r.ctrl_b;
                ADDR_IRQ_EN:    st_nxt.rdata = {6'h00, st_r.irq_en};
                ADDR_FLAGS:     st_nxt.rdata = {5'h00, st_r.ovf_flag, st_r.match_flag};
                ADDR_PIN_DIR:   st_nxt.rdata = {6'h00, st_r.pin_dir};
                ADDR_PORT_VAL:  st_nxt.rdata = {6'h00, st_r.port_val};
                default:        st_nxt.rdata = BYTE_RESET;
            endcase
        end

        // registered outputs; the output state is kept across modes
        st_nxt.irq = st_nxt.match_flag & st_nxt.irq_en;
        for (int c = 0; c < 2; c++) begin
            // any nonzero action hands the pin to the output state
            st_nxt.pin_out[c] = (act_of(st_nxt.ctrl_a, c) != ACT_NONE)
                                ? st_nxt.out_state[c] : st_nxt.port_val[c];
            st_nxt.pin_oe[c]  = st_nxt.pin_dir[c];
        end
    end

    // action field of the pending control value, channel a is index 0
    function automatic logic [1:0] act_of(input logic [7:0] ca, input int c);
        act_of = (c == 0) ? ca[CTRLA_ACTA_LSB +: 2] : ca[CTRLA_ACTB_LSB +: 2];
    endfunction

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // reset clears all, output state included
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else if (cen_i) begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o    = st_r.rdata;
    assign irq_o      = st_r.irq;
    assign ovf_flag_o = st_r.ovf_flag;
    assign pin_out_o  = st_r.pin_out;
    assign pin_oe_o   = st_r.pin_oe;
endmodule

// file: verif/tb_timer16_output_compare.sv
// self-checking bench of the timer output compare block
`timescale 1ns/10ps
module tb_timer16_output_compare;
    import tocmp_pkg::*;
    logic       mclk_i = 1'h0;
    logic       rstn_i = 1'h0;
    logic       cen_i = 1'h1;
    logic       timer_tick_i = 1'h0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'h0;
    logic       rd_i = 1'h0;
    logic [1:0] irq_ack_i = 2'h0;
    logic [7:0] rdata_o, rv;
    logic [1:0] irq_o, pin_out_o, pin_oe_o;
    logic       ovf_flag_o;
    int         errors = 0;
    int         n_compared = 0;

    // 125 MHz system clock
    always #4 mclk_i = ~mclk_i;

    tocmp_top i_dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .cen_i(cen_i), .timer_tick_i(timer_tick_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .irq_ack_i(irq_ack_i),
        .rdata_o(rdata_o), .irq_o(irq_o), .ovf_flag_o(ovf_flag_o), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o)
    );

    // --------------------
    // bus and tick helpers
    // --------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // the #1 lets the write edge settle before anyone looks
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'h1;
        @(posedge mclk_i);
        wr_i <= 1'h0;
        #1;
    endtask
    // high byte first, it only fills the shared latch
    task automatic w16(input logic [3:0] lo, input logic [15:0] v);
        wr(lo + 4'h1, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge mclk_i);
        rd_i <= 1'h0;
        #1 rv = rdata_o;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk_i);
            timer_tick_i <= 1'h1;
            @(posedge mclk_i);
            timer_tick_i <= 1'h0;
        end
        #1;
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // --------------------
    // scenarios
    // --------------------
    // reset state, direct compare reads past a dirty shared latch
    task automatic t_access;
        chk("pin out", pin_out_o, 2'h0);
        w16(ADDR_CMPA_LOW, 16'h1234);
        wr(ADDR_CNT_HIGH, 8'hab);
        rd(ADDR_CMPA_HIGH);
        chk("cmpa high", rv, 8'h12);
        rd(ADDR_CMPA_LOW);
        chk("cmpa low", rv, 8'h34);
        wr(ADDR_CMPB_LOW, 8'hcd);
        rd(ADDR_CMPB_HIGH);
        chk("cmpb latched high", rv, 8'hab);
        $display("end access");
    endtask
    // flag one tick after the match, cleared two ways, blocked by a count write
    task automatic t_match;
        wr(ADDR_CTRL_B, 8'h04);
        wr(ADDR_IRQ_EN, 8'h01);
        w16(ADDR_CMPA_LOW, 16'h0012);
        w16(ADDR_CNT_LOW, 16'h0010);
        tick(3);
        rd(ADDR_FLAGS);
        chk("flag early", rv, 8'h00);
        tick(1);
        rd(ADDR_FLAGS);
        chk("flag set", rv, 8'h01);
        chk("irq set", irq_o, 2'h1);
        wr(ADDR_FLAGS, 8'h00);
        rd(ADDR_FLAGS);
        chk("flag kept", rv, 8'h01);
        wr(ADDR_FLAGS, 8'h01);
        rd(ADDR_FLAGS);
        chk("flag cleared", rv, 8'h00);
        w16(ADDR_CNT_LOW, 16'h0011);
        tick(3);
        rd(ADDR_FLAGS);
        chk("flag again", rv, 8'h01);
        @(posedge mclk_i);
        irq_ack_i <= 2'h1;
        @(posedge mclk_i);
        irq_ack_i <= 2'h0;
        rd(ADDR_FLAGS);
        chk("flag acked", rv, 8'h00);
        w16(ADDR_CNT_LOW, 16'h0012);
        tick(3);
        rd(ADDR_FLAGS);
        chk("flag blocked", rv, 8'h00);
        $display("end match");
    endtask
    // normal mode wraps to zero and raises overflow on that tick
    task automatic t_wrap;
        w16(ADDR_CNT_LOW, 16'hfffe);
        tick(1);
        chk("ovf early", ovf_flag_o, 1'h0);
        tick(1);
        chk("ovf set", ovf_flag_o, 1'h1);
        rd(ADDR_CNT_LOW);
        chk("count low", rv, 8'h00);
        rd(ADDR_CNT_HIGH);
        chk("count high", rv, 8'h00);
        wr(ADDR_FLAGS, 8'h04);
        wr(ADDR_CTRL_B, 8'h00);
        $display("end wrap");
    endtask
    // forced compares walk every action on both channels
    task automatic t_force;
        logic [1:0] acts [4] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_TOGGLE};
        int sh;
        wr(ADDR_PIN_DIR, 8'h03);
        wr(ADDR_PORT_VAL, 8'h00);
        for (int ch = 0; ch < 2; ch++) begin
            sh = (ch == 0) ? CTRLA_ACTA_LSB : CTRLA_ACTB_LSB;
            for (int k = 0; k < 4; k++) begin
                wr(ADDR_CTRL_A, 8'(acts[k]) << sh);
                wr(ADDR_FORCE, 8'h01 << ch);
                chk("forced pin", pin_out_o[ch], (k == 0 || k == 2));
            end
            wr(ADDR_CTRL_A, 8'h00);
            wr(ADDR_PORT_VAL, 8'h01 << ch);
            wr(ADDR_FORCE, 8'h01 << ch);
            chk("port pin", pin_out_o[ch], 1'h1);
            wr(ADDR_CTRL_A, 8'(ACT_TOGGLE) << sh);
            chk("state kept", pin_out_o[ch], 1'h0);
            wr(ADDR_PIN_DIR, 8'h00);
            chk("pin oe", pin_oe_o, 2'h0);
            wr(ADDR_PIN_DIR, 8'h03);
            wr(ADDR_PORT_VAL, 8'h00);
        end
        rd(ADDR_FLAGS);
        chk("no force flag", rv, 8'h00);
        $display("end force");
    endtask
    // output state survives mode changes; force is ignored in pwm
    task automatic t_mode;
        wr(ADDR_CTRL_A, 8'(ACT_SET) << CTRLA_ACTA_LSB);
        wr(ADDR_FORCE, 8'h01);
        wr(ADDR_CTRL_B, 8'h01);
        chk("mode 4 keeps", pin_out_o[0], 1'h1);
        wr(ADDR_CTRL_A, 8'h81);
        chk("mode 5 keeps", pin_out_o[0], 1'h1);
        wr(ADDR_FORCE, 8'h01);
        chk("pwm force", pin_out_o[0], 1'h1);
        $display("end mode");
    endtask
    // pwm compare value waits in its buffer until the counter wraps
    task automatic t_buffer;
        w16(ADDR_CMPB_LOW, 16'h0077);
        rd(ADDR_CMPB_LOW);
        chk("buffer read", rv, 8'h77);
        wr(ADDR_CTRL_B, 8'h05);
        w16(ADDR_CNT_LOW, 16'h0070);
        wr(ADDR_FLAGS, 8'h07);
        tick(10);
        rd(ADDR_FLAGS);
        chk("no early b", rv[1], 1'h0);
        tick(260);
        rd(ADDR_FLAGS);
        chk("b after wrap", rv[1], 1'h1);
        $display("end buffer");
    endtask

    // main sequence after six reset cycles
    initial begin
        repeat (6) @(posedge mclk_i);
        rstn_i <= 1'h1;
        #1;
        t_access;
        t_match;
        t_wrap;
        t_force;
        t_mode;
        t_buffer;
        report_and_stop;
    end

    // watchdog, over twenty times the expected run
    initial begin
        repeat (20000) @(posedge mclk_i);
        errors++;
        report_and_stop;
    end
endmodule

// file: verif/tocmp_asserts.sv
// checker of the timer output compare block, bound to its top
`timescale 1ns/10ps
module tocmp_asserts
    import tocmp_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       rstn_i,
    input wire logic       cen_i,
    input wire logic       timer_tick_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [1:0] irq_ack_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] irq_o,
    input wire logic       ovf_flag_o,
    input wire logic [1:0] pin_out_o,
    input wire logic [1:0] pin_oe_o
);
    // --------------------
    // software settings
    // --------------------
    logic [1:0]  dir_r, port_r, en_r, en_d_r, acta_r;
    logic [3:0]  mode_r;
    logic [7:0]  tmp_r;
    logic [15:0] cmpa_r;
    logic        tmp_ok_r, cmpa_ok_r, we, re;
    assign we = wr_i && cen_i;
    assign re = rd_i && cen_i;

    // shadow copy; compare value only trusted while written and read in normal mode
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            {dir_r, port_r, en_r, en_d_r, acta_r} <= 10'h000;
            {mode_r, tmp_r, cmpa_r, tmp_ok_r, cmpa_ok_r} <= 30'h0;
        end else begin
            en_d_r <= en_r;
            if (we && addr_i == ADDR_PIN_DIR) dir_r <= wdata_i[1:0];
            if (we && addr_i == ADDR_PORT_VAL) port_r <= wdata_i[1:0];
            if (we && addr_i == ADDR_IRQ_EN) en_r <= wdata_i[1:0];
            if (we && addr_i == ADDR_CTRL_A) begin
                mode_r[1:0] <= wdata_i[1:0];
                acta_r      <= wdata_i[7:6];
            end
            if (we && addr_i == ADDR_CTRL_B) mode_r[3:2] <= wdata_i[1:0];
            if (we && addr_i[0] && addr_i < ADDR_CTRL_A) begin
                tmp_r    <= wdata_i;
                tmp_ok_r <= 1'h1;
            end
            if (re && (addr_i == ADDR_CNT_LOW || addr_i == ADDR_CAPT_LOW)) tmp_ok_r <= 1'h0;
            if (mode_r != WM_NORMAL) cmpa_ok_r <= 1'h0;
            if (we && addr_i == ADDR_CMPA_LOW) begin
                cmpa_r    <= {tmp_r, wdata_i};
                cmpa_ok_r <= tmp_ok_r && mode_r == WM_NORMAL;
            end
        end
    end

    // --------------------
    // assertions
    // --------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    chk_oe_dir: assert property (pin_oe_o == dir_r)
        else $error("pin enable differs from direction");
    chk_port_pass: assert property (
        acta_r == ACT_NONE |-> pin_out_o[0] == port_r[0])
        else $error("idle channel pin differs from port value");
    chk_irq_enable: assert property ((irq_o & ~(en_r | en_d_r)) == 2'h0)
        else $error("interrupt without enable");
    chk_cmp_read: assert property (
        re && addr_i == ADDR_CMPA_HIGH && cmpa_ok_r && mode_r == WM_NORMAL
        |=> rdata_o == cmpa_r[15:8])
        else $error("compare high byte read wrong");
    chk_ovf_tick: assert property ($rose(ovf_flag_o) |-> $past(timer_tick_i))
        else $error("overflow set without tick");
    chk_pin_cause: assert property (
        $changed(pin_out_o) |-> $past(timer_tick_i) || $past(wr_i) || !$past(rstn_i))
        else $error("pin moved without tick or write");
    chk_reset_out: assert property (
        $rose(rstn_i) |-> pin_out_o == 2'h0 && irq_o == 2'h0)
        else $error("outputs not cleared by reset");
    chk_irq_cause: assert property (
        $rose(irq_o[0]) |-> $past(timer_tick_i) || $past(timer_tick_i, 2)
                            || $past(wr_i) || $past(wr_i, 2))
        else $error("interrupt rose without tick or write");
endmodule

bind tocmp_top tocmp_asserts i_chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .cen_i(cen_i), .timer_tick_i(timer_tick_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .irq_ack_i(irq_ack_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .ovf_flag_o(ovf_flag_o), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o)
);
